// *** wdrc_pkg.sv ***
// Notes on behaviour
// RULE1: a reset-mode time-out gives a system reset pulse of one clock.
// RULE2: the start-up delay begins when that reset pulse falls.
// RULE3: the watchdog counter advances at a 128 kHz rate, not the bus clock.
// RULE4: restart instruction, disabled watchdog or any chip reset zero the counter.
// RULE5: an elapsed period with reset enabled resets the chip.
// RULE6: the fuse picks level 1 (free, initially off) or level 2 (always on).
// RULE7: at level 1 a plain write of one to reset enable turns it on.
// RULE8: level 1 disable: write change and reset enable, then new value in 4.
// RULE9: at level 2 the watchdog runs and reset enable reads one.
// RULE10: level 2 period change: change+reset enable, then period within 4.
// RULE11: the change enable bit clears itself four clocks after being set.
// RULE12: cause bits 3,2,1 mark watchdog, brown-out, pin; cleared by POR or zero.
// RULE13: cause bit 0 is set by power-on and cleared only by writing zero.
// RULE14: cause bits 7 to 4 always read zero.
// RULE15: interrupt flag set on time-out; cleared by vector or writing one.
// RULE16: request needs flag, interrupt enable and global enable together.
// RULE17: reset and interrupt enable pick the mode; the fuse forces reset mode.
// RULE18: combined mode: first time-out flags, second unserviced one resets.
// RULE19: reset enable reads one while the watchdog cause flag is set.
// RULE20: period select has its top bit at 5 and low bits at 2..0.
// RULE21: codes 0 to 9 give 2048 shifted left by the code ticks.
// RULE22: reserved codes 10 to 15 fall back to a valid lower code.
// RULE23: after reset, reset enable reads one if cause flag or fuse set.
// RULE24: restarts, settings and time-outs cross between rates safely.
package wdrc_pkg;
  localparam int CLK_HZ        = 250_000_000;
  localparam int TICK_HZ       = 128_000;
  localparam int TICK_DIV_DFLT = CLK_HZ / TICK_HZ;

  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] RCF_OFF = 12'h000;
  localparam logic [ADDR_W-1:0] WCS_OFF = 12'h004;

  // control/status field positions
  localparam int IRQF_B = 7;
  localparam int IRQE_B = 6;
  localparam int WDP3_B = 5;
  localparam int CE_B   = 4;
  localparam int RE_B   = 3;
  localparam int WDP_LO = 0;

  // reset cause field positions
  localparam int DOG_B = 3;
  localparam int BRN_B = 2;
  localparam int PIN_B = 1;
  localparam int POR_B = 0;
  localparam logic [3:0] RCF_RST = 4'h1;

  localparam logic [2:0] CE_WINDOW    = 3'h4;
  localparam int         PER_BASE_LOG = 11;
  localparam logic [3:0] PER_MAX_CODE = 4'h9;
  localparam int         CNT_W        = 20;

  // last count value of a period; reserved codes use the longest period
  function automatic logic [CNT_W-1:0] wdrc_last(input logic [3:0] code);
    logic [3:0] eff;
    eff = (code > PER_MAX_CODE) ? PER_MAX_CODE : code;
    return CNT_W'((64'h1 << (PER_BASE_LOG + int'(eff))) - 64'h1);
  endfunction
endpackage

// *** wdrc_top.sv ***
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ns
module wdrc_top
  import wdrc_pkg::*;
#(
  parameter int TICK_DIV = TICK_DIV_DFLT
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              safety_level_fuse,
  input  wire logic              restart_instruction,
  input  wire logic              vector_taken,
  input  wire logic              global_irq_enable,
  input  wire logic              brownout_rst_in,
  input  wire logic              pin_rst_in,
  output logic                   timeout_irq_req,
  output logic                   sys_reset_pulse,
  output logic                   delay_start
);

  if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_chk
    $error("TICK_DIV must lie in 1..65535");
  end

  // pin synchronisers: stage one feeds stage two only
  logic [1:0] fuse_s;
  logic [2:0] brn_s;
  logic [2:0] pin_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_s <= 2'h0;
      brn_s  <= 3'h0;
      pin_s  <= 3'h0;
    end else begin
      fuse_s <= {fuse_s[0], safety_level_fuse};
      brn_s  <= {brn_s[1:0], brownout_rst_in};
      pin_s  <= {pin_s[1:0], pin_rst_in};
    end
  end

  logic brn_ev;
  logic pin_ev;
  assign brn_ev = brn_s[1] & ~brn_s[2];
  assign pin_ev = pin_s[1] & ~pin_s[2];

  // fuse is a strap: caught once the synchroniser has settled, then
  // frozen; capturing earlier would latch the flops' reset value
  logic [1:0] fuse_age;
  logic [1:0] next_fuse_age;
  logic       fuse_cap;
  logic       fuse_lvl;
  logic       next_fuse_cap;
  logic       next_fuse_lvl;
  always_comb begin
    next_fuse_age = {fuse_age[0], 1'b1};
    next_fuse_cap = fuse_cap | fuse_age[1];
    next_fuse_lvl = (fuse_age[1] && !fuse_cap) ? fuse_s[1] : fuse_lvl;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_age <= 2'h0;
      fuse_cap <= 1'b0;
      fuse_lvl <= 1'b0;
    end else begin
      fuse_age <= next_fuse_age;
      fuse_cap <= next_fuse_cap;
      fuse_lvl <= next_fuse_lvl;
    end
  end

  // apb decode; zero wait states so every access completes at once
  logic wr_acc;
  logic wr_rcf;
  logic wr_wcs;
  logic hit;
  assign hit    = (paddr == RCF_OFF) || (paddr == WCS_OFF);
  assign wr_acc = psel & penable & pwrite;
  assign wr_rcf = wr_acc && (paddr == RCF_OFF);
  assign wr_wcs = wr_acc && (paddr == WCS_OFF);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // control register state
  logic       irq_f;
  logic       irq_e;
  logic       re;
  logic [3:0] wdp;
  logic [2:0] ce_cnt;
  logic [3:0] rcf;
  logic       ce;
  logic       eff_re;
  logic       ie;
  logic       running;
  logic       chip_rst;
  logic       tmo;
  assign ce       = (ce_cnt != 3'h0);
  assign eff_re   = fuse_lvl | re | rcf[DOG_B];   // [RULE9] [RULE19]
  assign ie       = irq_e & ~fuse_lvl;            // [RULE17]
  assign running  = eff_re | ie;                  // [RULE6]
  assign chip_rst = sys_reset_pulse | brn_ev | pin_ev;

  logic [7:0] wcs_rd;
  logic [7:0] rcf_rd;
  always_comb begin
    wcs_rd         = 8'h00;
    wcs_rd[IRQF_B] = irq_f;
    wcs_rd[IRQE_B] = irq_e;
    wcs_rd[WDP3_B] = wdp[3];                      // [RULE20]
    wcs_rd[CE_B]   = ce;
    wcs_rd[RE_B]   = eff_re;                      // [RULE23]
    wcs_rd[2:0]    = wdp[2:0];
    rcf_rd         = {4'h0, rcf};                 // [RULE14]
  end

  logic       next_irq_f;
  logic       next_irq_e;
  logic       next_re;
  logic [3:0] next_wdp;
  logic [2:0] next_ce_cnt;
  logic [3:0] next_rcf;
  logic [3:0] wr_wdp;
  logic       do_rst;
  logic       next_pulse;
  assign wr_wdp = {pwdata[WDP3_B], pwdata[WDP_LO+2:WDP_LO]};

  // time-out action: reset at once when interrupts are off; with both enabled, interrupt first, reset when already flagged
  always_comb begin
    do_rst = 1'b0;
    if (tmo) begin
      if (eff_re && (!ie || irq_f))
        do_rst = 1'b1;                            // [RULE5] [RULE18]
    end
    next_pulse = do_rst & ~sys_reset_pulse;       // [RULE1]
  end

  // software writes, hardware clears, then hardware sets (sets win)
  always_comb begin
    next_irq_f  = irq_f;
    next_irq_e  = irq_e;
    next_re     = re;
    next_wdp    = wdp;
    next_ce_cnt = ce ? ce_cnt - 3'h1 : 3'h0;      // [RULE11]
    next_rcf    = rcf;
    if (wr_rcf)
      next_rcf = rcf & pwdata[3:0];               // [RULE12] [RULE13]
    if (chip_rst) begin
      next_irq_f  = 1'b0;
      next_irq_e  = 1'b0;
      next_re     = 1'b0;
      next_wdp    = 4'h0;
      next_ce_cnt = 3'h0;
    end else begin
      if (wr_wcs) begin
        next_irq_e = pwdata[IRQE_B];
        if (pwdata[IRQF_B])
          next_irq_f = 1'b0;                      // [RULE15]
        if (!fuse_lvl)
          next_wdp = wr_wdp;                      // [RULE6]
        if (pwdata[CE_B] && pwdata[RE_B]) begin
          next_ce_cnt = CE_WINDOW;                // [RULE8] [RULE10]
          next_re     = 1'b1;
        end else begin
          if (pwdata[RE_B])
            next_re = 1'b1;                       // [RULE7]
          else if (ce && !rcf[DOG_B])
            next_re = 1'b0;                       // [RULE8] [RULE19]
          if (fuse_lvl && ce)
            next_wdp = wr_wdp;                    // [RULE10]
          if (ce)
            next_ce_cnt = 3'h0;
        end
      end
      if (vector_taken) begin
        next_irq_f = 1'b0;                        // [RULE15]
        if (eff_re)
          next_irq_e = 1'b0;                      // [RULE18]
      end
      if (tmo && ie && !do_rst)
        next_irq_f = 1'b1;                        // [RULE15] [RULE18]
    end
    if (sys_reset_pulse)
      next_rcf[DOG_B] = 1'b1;                     // [RULE12]
    if (brn_ev)
      next_rcf[BRN_B] = 1'b1;                     // [RULE12]
    if (pin_ev)
      next_rcf[PIN_B] = 1'b1;                     // [RULE12]
  end

  // power-on reset sets only the power-on cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_f           <= 1'b0;
      irq_e           <= 1'b0;
      re              <= 1'b0;
      wdp             <= 4'h0;
      ce_cnt          <= 3'h0;
      rcf             <= RCF_RST;                 // [RULE13]
      sys_reset_pulse <= 1'b0;
      delay_start     <= 1'b0;
    end else begin
      irq_f           <= next_irq_f;
      irq_e           <= next_irq_e;
      re              <= next_re;
      wdp             <= next_wdp;
      ce_cnt          <= next_ce_cnt;
      rcf             <= next_rcf;
      sys_reset_pulse <= next_pulse;
      delay_start     <= sys_reset_pulse;         // [RULE2]
    end
  end

  assign timeout_irq_req = irq_f & irq_e & global_irq_enable; // [RULE16]

  // 128 kHz tick as an enable; the counter shares the bus clock, so every
  // setting and restart it sees is already in its own domain
  logic [15:0]      tick_cnt;
  logic             tick;
  logic [CNT_W-1:0] wd_cnt;
  logic [15:0]      next_tick_cnt;
  logic [CNT_W-1:0] next_wd_cnt;
  logic [CNT_W-1:0] last;
  assign tick = (tick_cnt == 16'(TICK_DIV - 1));  // [RULE3] [RULE24]
  assign last = wdrc_last(wdp);                   // [RULE21] [RULE22]
  assign tmo  = tick && running && (wd_cnt >= last);

  always_comb begin
    next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
    next_wd_cnt   = wd_cnt;
    if (restart_instruction || !running || chip_rst)
      next_wd_cnt = '0;                           // [RULE4]
    else if (tick)
      next_wd_cnt = (wd_cnt >= last) ? '0 : wd_cnt + 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 16'h0000;
      wd_cnt   <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
      wd_cnt   <= next_wd_cnt;
    end
  end

  // read data is captured in the setup cycle, held through access
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = prdata;
    if (psel && !penable) begin
      unique case (paddr)
        RCF_OFF: next_prdata = {24'h000000, rcf_rd};
        WCS_OFF: next_prdata = {24'h000000, wcs_rd};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else
      prdata <= next_prdata;
  end

  // checks on the block's own behaviour
  sequence s_flagged_tmo;
    tmo && ie && eff_re && irq_f;
  endsequence

  sequence s_window_open;
    wr_wcs && pwdata[CE_B] && pwdata[RE_B] && !chip_rst;
  endsequence

  property p_pulse_one;
    @(posedge pclk) disable iff (!presetn)
      sys_reset_pulse |=> !sys_reset_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) // [RULE1]
    else $error("reset pulse longer than one cycle");

  property p_delay_start;
    @(posedge pclk) disable iff (!presetn)
      $fell(sys_reset_pulse) |-> delay_start;
  endproperty
  a_delay_start: assert property (p_delay_start) // [RULE2]
    else $error("delay start missing at pulse fall");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      restart_instruction |=> (wd_cnt == '0);
  endproperty
  a_restart: assert property (p_restart) // [RULE4]
    else $error("counter not cleared by restart");

  property p_stopped;
    @(posedge pclk) disable iff (!presetn)
      !running |=> (wd_cnt == '0);
  endproperty
  a_stopped: assert property (p_stopped) // [RULE4]
    else $error("counter not held at zero while disabled");

  property p_lvl1_set;
    @(posedge pclk) disable iff (!presetn)
      (wr_wcs && pwdata[RE_B] && !chip_rst) |=> wcs_rd[RE_B];
  endproperty
  a_lvl1_set: assert property (p_lvl1_set) // [RULE7]
    else $error("plain write did not enable reset");

  property p_ce_open;
    @(posedge pclk) disable iff (!presetn)
      s_window_open |=> ce;
  endproperty
  a_ce_open: assert property (p_ce_open) // [RULE11]
    else $error("change enable did not open");

  // a write inside the window closes it early or, with change and reset enable, reopens it, so only quiet windows count
  property p_ce_window;
    @(posedge pclk) disable iff (!presetn)
      s_window_open ##1 (!wr_wcs && !chip_rst)[*3] |=>
        ce ##1 (!ce || $past(wr_wcs));
  endproperty
  a_ce_window: assert property (p_ce_window) // [RULE11]
    else $error("change enable window not four cycles");

  property p_lvl2_re;
    @(posedge pclk) disable iff (!presetn)
      fuse_lvl |-> wcs_rd[RE_B] && running;
  endproperty
  a_lvl2_re: assert property (p_lvl2_re) // [RULE9]
    else $error("level two watchdog not enabled");

  property p_rsv_zero;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && paddr == RCF_OFF) |=> (prdata[7:4] == 4'h0);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) // [RULE14]
    else $error("reserved cause bits not zero");

  property p_irq_gate;
    @(posedge pclk) disable iff (!presetn)
      timeout_irq_req |-> global_irq_enable && irq_e && irq_f;
  endproperty
  a_irq_gate: assert property (p_irq_gate) // [RULE16]
    else $error("interrupt request without all enables");

  property p_dog_re;
    @(posedge pclk) disable iff (!presetn)
      rcf[DOG_B] |-> wcs_rd[RE_B];
  endproperty
  a_dog_re: assert property (p_dog_re) // [RULE19]
    else $error("reset enable low while cause flag set");

  property p_dog_flag;
    @(posedge pclk) disable iff (!presetn)
      sys_reset_pulse |=> rcf[DOG_B] ##1 delay_start == 1'b0;
  endproperty
  a_dog_flag: assert property (p_dog_flag) // [RULE12]
    else $error("watchdog cause flag not set");

  property p_second_tmo;
    @(posedge pclk) disable iff (!presetn)
      s_flagged_tmo |=> sys_reset_pulse;
  endproperty
  a_second_tmo: assert property (p_second_tmo) // [RULE18]
    else $error("unserviced second time-out did not reset");

  property p_first_tmo;
    @(posedge pclk) disable iff (!presetn)
      (tmo && ie && !irq_f && !chip_rst) |=> irq_f && !sys_reset_pulse;
  endproperty
  a_first_tmo: assert property (p_first_tmo) // [RULE15]
    else $error("first time-out did not raise flag");

endmodule

// *** wdrc_core_model.sv ***
`timescale 1ns/1ns
// core stand-in: kicks the dog, serves its vector, counts start-up delays
module wdrc_core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic kick_en,
  input  wire logic serve_en,
  input  wire logic gie_en,
  input  wire logic timeout_irq_req,
  input  wire logic delay_start,
  output logic      restart_instruction,
  output logic      vector_taken,
  output logic      global_irq_enable,
  output int        n_delay
);
  logic [9:0] kick_cnt;

  // every core action is registered so it lands off the sampling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kick_cnt            <= 10'h000;
      restart_instruction <= 1'b0;
      vector_taken        <= 1'b0;
      global_irq_enable   <= 1'b0;
      n_delay             <= 0;
    end else begin
      kick_cnt            <= kick_cnt + 10'h001;
      restart_instruction <= kick_en && (kick_cnt == 10'h000);
      // one vector per request: the gap lets the flag drop first
      vector_taken <= serve_en && timeout_irq_req && !vector_taken;
      global_irq_enable <= gie_en;
      if (delay_start) n_delay <= n_delay + 1;
    end
  end
endmodule

// *** watchdog_with_reset_cause_flags_tb_top.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module watchdog_with_reset_cause_flags_tb_top;
  import wdrc_pkg::*;
  localparam int TD   = 4;
  localparam int PER0 = 2048 * TD;
  logic              pclk, presetn, psel, penable, pwrite, safety_level_fuse;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic              pready, pslverr, timeout_irq_req, sys_reset_pulse;
  logic              delay_start, restart_instruction, vector_taken;
  logic              global_irq_enable, brownout_rst_in, pin_rst_in;
  logic              kick_en, serve_en, gie_en;
  logic [32:0]       got;
  logic [32:0]       exp_q[$];
  int                n_delay, n_mismatch, samples_checked;

  wdrc_top #(.TICK_DIV(TD)) u_wdrc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .safety_level_fuse(safety_level_fuse),
    .restart_instruction(restart_instruction), .vector_taken(vector_taken),
    .global_irq_enable(global_irq_enable), .brownout_rst_in(brownout_rst_in),
    .pin_rst_in(pin_rst_in), .timeout_irq_req(timeout_irq_req),
    .sys_reset_pulse(sys_reset_pulse), .delay_start(delay_start));

  wdrc_core_model u_wdrc_core_model (
    .pclk(pclk), .presetn(presetn), .kick_en(kick_en), .serve_en(serve_en),
    .gie_en(gie_en), .timeout_irq_req(timeout_irq_req),
    .delay_start(delay_start), .restart_instruction(restart_instruction),
    .vector_taken(vector_taken), .global_irq_enable(global_irq_enable),
    .n_delay(n_delay));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tdone(input string name);
    $display("test %s finished", name);
  endtask

  // one APB transfer; hold keeps the bus for a back-to-back follow-up
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d, input logic [32:0] e,
                      input bit hold);
    int n;
    if (!w) exp_q.push_back(e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      wrap_up();
    end
    if (!hold) begin
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v,
                    input bit hold = 1'b0);
    xfer(1'b1, a, {24'h000000, v}, 33'h000000000, hold);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] v,
                    input bit hold = 1'b0);
    xfer(1'b0, a, 32'h00000000, {25'h0000000, v}, hold);
  endtask

  // bounded wait on the irq request (0) or the reset pulse (1)
  task automatic wait_for(input bit pulse, input int bound, output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (((pulse ? sys_reset_pulse : timeout_irq_req) !== 1'b1)
               && n < bound);
    if (n >= bound) begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  // read results are compared in the access cycle that carries them
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      got = {pslverr, prdata};
      if (exp_q.size() == 0) n_mismatch++;
      else `CHK(got, exp_q.pop_front())
    end
  end

  initial begin
    int          r;
    int          n;
    logic [7:0]  v;
    {presetn, psel, penable, pwrite, safety_level_fuse} = 5'h00;
    {brownout_rst_in, pin_rst_in, kick_en, serve_en, gie_en} = 5'h00;
    paddr  = 12'h000;
    pwdata = 32'h00000000;
    void'($urandom(27065));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(RCF_OFF, 8'h01);
    rd(WCS_OFF, 8'h00);
    xfer(1'b0, 12'h008, 32'h00000000, {1'b1, 32'h00000000}, 1'b0);
    wr(RCF_OFF, 8'h00);
    rd(RCF_OFF, 8'h00);
    tdone("reset values");
    wr(WCS_OFF, 8'h08);
    rd(WCS_OFF, 8'h08);
    r = $urandom_range(9, 0);
    v = 8'h08 | (8'(r >> 3) << 5) | 8'(r & 7);
    wr(WCS_OFF, v);
    rd(WCS_OFF, v);
    wr(WCS_OFF, 8'h18, 1'b1);
    wr(WCS_OFF, 8'h00, 1'b1);
    rd(WCS_OFF, 8'h00);
    wr(WCS_OFF, 8'h08);
    wr(WCS_OFF, 8'h18, 1'b1);
    rd(WCS_OFF, 8'h18);
    repeat (8) @(posedge pclk);
    rd(WCS_OFF, 8'h08);
    wr(WCS_OFF, 8'h00);
    rd(WCS_OFF, 8'h08);
    tdone("level one");
    // kicks every 1024 clocks, well inside the shortest period
    kick_en <= 1'b1;
    repeat (12288) @(posedge pclk);
    kick_en <= 1'b0;
    `CHK(n_delay == 0, 1'b1)
    wr(WCS_OFF, 8'h18, 1'b1);
    wr(WCS_OFF, 8'h00);
    tdone("restart");
    wr(WCS_OFF, 8'h40);
    repeat (PER0 + 200) @(posedge pclk);
    @(negedge pclk);
    `CHK(timeout_irq_req, 1'b0)
    @(posedge pclk);
    rd(WCS_OFF, 8'hC0);
    wr(WCS_OFF, 8'hC0);
    rd(WCS_OFF, 8'h40);
    gie_en   <= 1'b1;
    serve_en <= 1'b1;
    wait_for(1'b0, PER0 + 100, n);
    @(posedge pclk);
    repeat (3) @(posedge pclk);
    rd(WCS_OFF, 8'h40);
    wr(WCS_OFF, 8'h00);
    serve_en <= 1'b0;
    tdone("interrupt mode");
    wr(WCS_OFF, 8'h48);
    wait_for(1'b0, PER0 + 100, n);
    `CHK(n inside {[PER0 - 3*TD : PER0 + 3*TD + 20]}, 1'b1)
    `CHK(sys_reset_pulse, 1'b0)
    wait_for(1'b1, PER0 + 100, n);
    `CHK(n inside {[PER0 - 3*TD : PER0 + 3*TD + 20]}, 1'b1)
    @(negedge pclk);
    `CHK(sys_reset_pulse, 1'b0)
    `CHK(delay_start, 1'b1)
    @(posedge pclk);
    rd(RCF_OFF, 8'h08);
    rd(WCS_OFF, 8'h08);
    wr(WCS_OFF, 8'h18, 1'b1);
    wr(WCS_OFF, 8'h00, 1'b1);
    rd(WCS_OFF, 8'h08);
    wr(RCF_OFF, 8'h00);
    wr(WCS_OFF, 8'h18, 1'b1);
    wr(WCS_OFF, 8'h00, 1'b1);
    rd(WCS_OFF, 8'h00);
    tdone("combined mode");
    brownout_rst_in <= 1'b1;
    repeat (4) @(posedge pclk);
    brownout_rst_in <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(RCF_OFF, 8'h04);
    pin_rst_in <= 1'b1;
    repeat (4) @(posedge pclk);
    pin_rst_in <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(RCF_OFF, 8'h06);
    tdone("cause flags");
    // second power-on with the fuse programmed
    safety_level_fuse <= 1'b1;
    presetn           <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(RCF_OFF, 8'h01);
    rd(WCS_OFF, 8'h08);
    wr(WCS_OFF, 8'h00);
    rd(WCS_OFF, 8'h08);
    wr(WCS_OFF, 8'h18, 1'b1);
    wr(WCS_OFF, 8'h21, 1'b1);
    rd(WCS_OFF, 8'h29);
    tdone("level two");
    wrap_up();
  end
endmodule
